// ### bench/eerc_partner.sv
// Purpose: Stack memory and pipeline stand-in for the sequencer
// Assumes: All outputs change on the rising clk edge
// Notes:   Random stalls; vector fetch answers only when stacking is idle
`timescale 1ns/100ps
module eerc_partner (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire eerc_pkg::eerc_stk_t stk_req,
   input  wire logic                vec_fetch,
   output logic                     stk_ready = 1'b0,
   output logic                     vec_done = 1'b0,
   output logic                     first_exec = 1'b0,
   output int                       pushes = 0,
   output int                       pops = 0,
   output int                       bad_order = 0
);
   int fw = 0;
   int wt = -1;
   // ==========================================
   // Stack memory, refuses one cycle in four
   always @(posedge clk) begin
      stk_ready <= ($urandom % 4) != 0;
      if (!stk_req.valid) fw <= 0;
      else if (stk_ready) begin
         fw <= fw + 1;
         if (!stk_req.push) pops <= pops + 1;
         else begin
            pushes <= pushes + 1;
            if (stk_req.word != 5'(fw)) bad_order <= bad_order + 1;
         end
      end
   end
   // ==========================================
   // Pipeline, restarts its wait on every new fetch
   always @(posedge clk) begin
      vec_done <= 1'b0;
      first_exec <= 1'b0;
      if (rst) wt <= -1;
      else if (vec_fetch) wt <= 0;
      else if (wt >= 0 && wt < 3) wt <= wt + 1;
      else if (wt == 3 && !stk_req.valid) begin
         vec_done <= 1'b1;
         first_exec <= 1'b1;
         wt <= -1;
      end
   end
endmodule // eerc_partner

// ### bench/test_exception_entry_return_control.sv
// Purpose: Self-checking bench for the exception sequencer
// Assumes: Mask limit held at 80 for the whole run
// Notes:   Eligible sources stay pending until their handler is entered
`timescale 1ns/100ps
module test_exception_entry_return_control;
   logic                clk = 1'b0, rst = 1'b1, fp_active = 1'b0, fp_space = 1'b0, handler_done = 1'b0;
   logic [7:0]          pend = 8'h00, mask_limit = 8'h80;
   logic [63:0]         pend_prio = 64'h0;
   logic                stk_ready, vec_done, first_exec, vec_fetch, take_ack, handler_mode, restore_done;
   eerc_pkg::eerc_stk_t stk_req;
   logic [2:0]          vec_idx, act_idx;
   logic [3:0]          nest_depth;
   int                  pushes, pops, bad_order, num_errors = 0, n_tests = 0;
   int                  acks = 0, fetches = 0, cyc = 0, p0, q0, a0, f0, lastv = 0;
   int                  m[$];
   eerc_core dut (.clk(clk), .rst(rst), .pend(pend), .pend_prio(pend_prio), .mask_limit(mask_limit),
      .fp_active(fp_active), .fp_space(fp_space), .handler_done(handler_done), .first_exec(first_exec),
      .stk_ready(stk_ready), .vec_done(vec_done), .stk_req(stk_req), .vec_fetch(vec_fetch), .vec_idx(vec_idx),
      .take_ack(take_ack), .act_idx(act_idx), .handler_mode(handler_mode), .nest_depth(nest_depth),
      .restore_done(restore_done));
   eerc_partner far (.clk(clk), .rst(rst), .stk_req(stk_req), .vec_fetch(vec_fetch), .stk_ready(stk_ready),
      .vec_done(vec_done), .first_exec(first_exec), .pushes(pushes), .pops(pops), .bad_order(bad_order));
   initial forever #5 clk = ~clk;
   // ==========================================
   // Source model and timeout
   always @(posedge clk) begin
      if (vec_done) pend[act_idx] <= 1'b0;
      acks += take_ack;
      fetches += vec_fetch;
      if (vec_fetch) lastv = vec_idx;
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         close_out;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compares=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Bounded wait, so a lost pulse costs one mismatch, not a hang
   task automatic await(ref logic s);
      int k;
      k = 0;
      while (s !== 1'b1 && k < 300) begin
         @(negedge clk);
         k++;
      end
      chk(k < 300, 1);
   endtask
   task automatic enter(input int i, input logic [7:0] p, input int j, input logic [7:0] q);
      @(posedge clk);
      pend_prio[i*8+:8] <= p;
      pend_prio[j*8+:8] <= q;
      pend[i] <= 1'b1;
      pend[j] <= 1'b1;
      m.push_back(q < p ? j : i);
      p0 = pushes;
      await(take_ack);
   endtask
   task automatic in_handler;
      await(vec_done);
      @(negedge clk);
      chk(nest_depth, m.size());
      chk(act_idx, m[m.size()-1]);
      chk(handler_mode, 1);
   endtask
   task automatic done_hnd;
      @(posedge clk);
      handler_done <= 1'b1;
      @(posedge clk);
      handler_done <= 1'b0;
      q0 = pops;
   endtask
   task automatic ret(input int n);
      done_hnd;
      await(restore_done);
      chk(pops - q0, n);
      void'(m.pop_back());
      chk(handler_mode, m.size() != 0);
   endtask
   // ==========================================
   // Scenarios
   initial begin
      void'($urandom(32'he644e3bd));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      enter(3, 8'h40, 3, 8'h40);
      in_handler;
      chk(pushes - p0, 8);
      chk(act_idx, 3);
      enter(5, 8'h10, 5, 8'h10);
      in_handler;
      chk(nest_depth, 2);
      @(posedge clk);
      pend_prio[55:48] <= 8'h80 + 8'($urandom % 128);
      pend[6] <= 1'b1;
      ret(8);
      chk(act_idx, 3);
      ret(8);
      a0 = acks;
      repeat (30) @(negedge clk);
      chk(acks - a0, 0);
      @(posedge clk);
      pend[6] <= 1'b0;
      $display("nesting test done");
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         fp_active <= 1'b1;
         fp_space <= s[0];
         enter(2, 8'h20, 2, 8'h20);
         in_handler;
         chk(pushes - p0, s ? 18 : 8);
         ret(s ? 18 : 8);
      end
      @(posedge clk);
      fp_active <= 1'b0;
      $display("fp frame test done");
      a0 = acks;
      f0 = fetches;
      enter(1, 8'h60, 1, 8'h60);
      @(posedge clk);
      pend_prio[39:32] <= 8'h08;
      pend[4] <= 1'b1;
      m[m.size()-1] = 4;
      in_handler;
      chk(act_idx, 4);
      chk(fetches - f0, 2);
      chk(lastv, 4);
      chk(pushes - p0, 8);
      chk(acks - a0, 1);
      done_hnd;
      m[m.size()-1] = 1;
      in_handler;
      chk(pops - q0, 0);
      chk(act_idx, 1);
      chk(lastv, 1);
      ret(8);
      $display("late arrival test done");
      enter(0, 8'h30, 7, 8'h20);
      in_handler;
      chk(act_idx, 7);
      done_hnd;
      m[m.size()-1] = 0;
      in_handler;
      chk(pops - q0, 0);
      chk(act_idx, 0);
      chk(lastv, 0);
      ret(8);
      chk(bad_order, 0);
      $display("chaining test done");
      close_out;
   end
endmodule // test_exception_entry_return_control

// ### logic/eerc_core.sv
// Purpose: Sequences exception entry, late arrival, chaining and return
// Assumes: All inputs come from logic on clk; lower priority value is more urgent
// Notes:   One stack word moves per cycle the memory accepts it
//
// Overview of operation
// - Return unstacks when nothing eligible is pending
// - Eligible pending at return chains without unstacking if it beats the parent
// - Higher priority during stacking switches vector fetch
// - Late arrival never restarts the stacking sequence
// - Late arrival accepted only before handler executes
// - Late arrival handler returns with normal chaining
// - Take exception in thread mode or when outranking
// - Preempted exceptions stay active as nested
// - Only priorities above mask limits are eligible
// - Ordinary entry pushes an eight word frame
// - Floating point state stacked when in use
// - Without reserved space, basic frame only
`timescale 1ns/100ps
`include "eerc_map.svh"

module eerc_core #(
   parameter int NUM_SRC = `EERC_NUM_SRC,
   parameter int PRIO_W  = `EERC_PRIO_W,
   parameter int IDX_W   = `EERC_IDX_W
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [NUM_SRC-1:0]    pend,
   input  wire logic [NUM_SRC*PRIO_W-1:0] pend_prio,
   input  wire logic [PRIO_W-1:0]     mask_limit,
   input  wire logic                  fp_active,
   input  wire logic                  fp_space,
   input  wire logic                  handler_done,
   input  wire logic                  first_exec,
   input  wire logic                  stk_ready,
   input  wire logic                  vec_done,
   output eerc_pkg::eerc_stk_t        stk_req,
   output logic                       vec_fetch,
   output logic [IDX_W-1:0]           vec_idx,
   output logic                       take_ack,
   output logic [IDX_W-1:0]           act_idx,
   output logic                       handler_mode,
   output logic [3:0]                 nest_depth,
   output logic                       restore_done
);

   // ==========================================================
   // Selection of the most urgent eligible source
   logic [PRIO_W-1:0] best_prio;
   logic [IDX_W-1:0]  best_idx;
   logic              best_ok;

   always_comb begin
      best_prio = `EERC_PRIO_NONE;
      best_idx  = '0;
      best_ok   = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         // Strictly below the mask limit value counts as above the limit
         if (pend[i] && pend_prio[i*PRIO_W +: PRIO_W] < mask_limit &&
             pend_prio[i*PRIO_W +: PRIO_W] < best_prio) begin
            best_prio = pend_prio[i*PRIO_W +: PRIO_W];
            best_idx  = IDX_W'(i);
            best_ok   = 1'b1;
         end
      end
   end

   // ==========================================================
   // Nesting stack of active priorities
   localparam int DEPTH = 8;
   eerc_pkg::eerc_state_t state_q;
   logic [PRIO_W-1:0] prio_stk_q [DEPTH];
   logic [IDX_W-1:0]  idx_stk_q  [DEPTH];
   logic [3:0]        depth_q;
   logic [PRIO_W-1:0] cur_prio;
   logic              outranks;

   assign cur_prio = (depth_q == 4'h0) ? `EERC_PRIO_NONE : prio_stk_q[3'(depth_q - 4'h1)];
   // Thread mode has no active priority, so any eligible source outranks it
   assign outranks = best_ok && (best_prio < cur_prio);

   // ==========================================================
   // Frame sequencing
   logic [4:0] word_q;
   logic [4:0] frame_len_q;
   logic       late_ok;
   logic       take_new;

   assign late_ok  = (state_q == eerc_pkg::ST_STACK) || (state_q == eerc_pkg::ST_VECTOR);
   assign take_new = outranks && (state_q == eerc_pkg::ST_THREAD ||
                     state_q == eerc_pkg::ST_HANDLER);

   // ==========================================================
   // Return decision: chain only when the waiting source beats the parent
   logic       parent_ok;
   logic       chain_now;

   assign parent_ok = (depth_q == 4'h1) ||
                      (depth_q > 4'h1 && best_prio < prio_stk_q[3'(depth_q - 4'h2)]);
   assign chain_now = (state_q == eerc_pkg::ST_HANDLER) && handler_done && !take_new &&
                      best_ok && parent_ok;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q     <= eerc_pkg::ST_THREAD;
         word_q      <= 5'h00;
         frame_len_q <= 5'h00;
         depth_q     <= 4'h0;
         for (int i = 0; i < DEPTH; i++) begin
            prio_stk_q[i] <= '0;
            idx_stk_q[i]  <= '0;
         end
      end else begin
         unique case (state_q)
            eerc_pkg::ST_THREAD, eerc_pkg::ST_HANDLER: begin
               if (take_new && depth_q < 4'(DEPTH)) begin
                  prio_stk_q[3'(depth_q)] <= best_prio;
                  idx_stk_q[3'(depth_q)]  <= best_idx;
                  depth_q     <= depth_q + 4'h1;
                  word_q      <= 5'h00;
                  // FP state only when in use and space is reserved
                  frame_len_q <= (fp_active && fp_space) ? 5'(`EERC_FP_WORDS)
                                                         : 5'(`EERC_BASIC_WORDS);
                  state_q     <= eerc_pkg::ST_STACK;
               end else if (state_q == eerc_pkg::ST_HANDLER && handler_done) begin
                  if (chain_now) begin
                     // Chained handler replaces the finished one, no pop
                     prio_stk_q[3'(depth_q - 4'h1)] <= best_prio;
                     idx_stk_q[3'(depth_q - 4'h1)]  <= best_idx;
                     state_q <= eerc_pkg::ST_VECTOR;
                  end else begin
                     word_q  <= 5'h00;
                     state_q <= eerc_pkg::ST_UNSTACK;
                  end
               end
            end
            eerc_pkg::ST_STACK: begin
               if (late_ok && outranks) begin
                  // Retarget only; frame counter keeps running
                  prio_stk_q[3'(depth_q - 4'h1)] <= best_prio;
                  idx_stk_q[3'(depth_q - 4'h1)]  <= best_idx;
               end
               if (stk_ready) begin
                  word_q <= word_q + 5'h01;
                  if (word_q == frame_len_q - 5'h01) begin
                     state_q <= eerc_pkg::ST_VECTOR;
                  end
               end
            end
            eerc_pkg::ST_VECTOR: begin
               if (late_ok && outranks) begin
                  prio_stk_q[3'(depth_q - 4'h1)] <= best_prio;
                  idx_stk_q[3'(depth_q - 4'h1)]  <= best_idx;
               end else if (vec_done && first_exec) begin
                  state_q <= eerc_pkg::ST_HANDLER;
               end
            end
            eerc_pkg::ST_UNSTACK: begin
               if (stk_ready) begin
                  word_q <= word_q + 5'h01;
                  if (word_q == frame_len_q - 5'h01) begin
                     depth_q <= depth_q - 4'h1;
                     state_q <= (depth_q == 4'h1) ? eerc_pkg::ST_THREAD : eerc_pkg::ST_HANDLER;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs
   logic vec_fetch_q;
   logic take_q;
   logic restore_q;
   logic [IDX_W-1:0] vec_idx_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         vec_fetch_q <= 1'b0;
         take_q      <= 1'b0;
         restore_q   <= 1'b0;
         vec_idx_q   <= '0;
      end else begin
         take_q      <= take_new && depth_q < 4'(DEPTH);
         restore_q   <= state_q == eerc_pkg::ST_UNSTACK && stk_ready && word_q == frame_len_q - 5'h01;
         vec_fetch_q <= (late_ok && outranks) || (take_new && depth_q < 4'(DEPTH)) || chain_now;
         vec_idx_q   <= best_idx;
      end
   end

   assign stk_req.valid = (state_q == eerc_pkg::ST_STACK) || (state_q == eerc_pkg::ST_UNSTACK);
   assign stk_req.word  = word_q;
   assign stk_req.push  = (state_q == eerc_pkg::ST_STACK);
   assign vec_fetch     = vec_fetch_q;
   assign vec_idx       = vec_idx_q;
   assign take_ack      = take_q;
   assign act_idx       = (depth_q == 4'h0) ? '0 : idx_stk_q[3'(depth_q - 4'h1)];
   assign handler_mode  = (state_q != eerc_pkg::ST_THREAD);
   assign nest_depth    = depth_q;
   assign restore_done  = restore_q;

   // ==========================================================
   // Checks
   a_mask_gate: assert property (@(posedge clk) disable iff (rst)
      take_new |-> best_prio < mask_limit)
      else $error("Taken exception not above mask limit");

   a_basic_frame: assert property (@(posedge clk) disable iff (rst)
      (take_new && !(fp_active && fp_space) && depth_q < 4'(DEPTH)) |=> frame_len_q == 5'h08)
      else $error("Basic frame not eight words");

   a_fp_frame: assert property (@(posedge clk) disable iff (rst)
      (take_new && fp_active && fp_space && depth_q < 4'(DEPTH)) |=> frame_len_q == 5'h12)
      else $error("FP frame length wrong");

   sequence s_stack_step;
      state_q == eerc_pkg::ST_STACK && stk_ready && word_q != frame_len_q - 5'h01;
   endsequence
   a_stack_steady: assert property (@(posedge clk) disable iff (rst)
      s_stack_step |=> word_q == $past(word_q) + 5'h01 && state_q == eerc_pkg::ST_STACK)
      else $error("Stacking disturbed");

   a_late_fetch: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_STACK && outranks) |=> vec_fetch)
      else $error("Late arrival did not refetch vector");

   a_no_late_exec: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_HANDLER && !handler_done && !take_new) |=> $stable(act_idx))
      else $error("Late arrival accepted in handler");

   a_chain_nopop: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_HANDLER && handler_done && !take_new && best_ok && depth_q == 4'h1)
      |=> state_q == eerc_pkg::ST_VECTOR && depth_q == 4'h1)
      else $error("Chain did not skip unstacking");

   a_return_pop: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_HANDLER && handler_done && !best_ok)
      |=> state_q == eerc_pkg::ST_UNSTACK)
      else $error("Return did not unstack");

   a_nest_push: assert property (@(posedge clk) disable iff (rst)
      (take_new && depth_q < 4'(DEPTH)) |=> depth_q == $past(depth_q) + 4'h1)
      else $error("Nesting depth not raised");

   a_chain_fetch: assert property (@(posedge clk) disable iff (rst)
      chain_now |=> vec_fetch && state_q == eerc_pkg::ST_VECTOR && depth_q == $past(depth_q))
      else $error("Chain did not fetch the next vector");

   a_chain_target: assert property (@(posedge clk) disable iff (rst)
      chain_now |=> act_idx == $past(best_idx))
      else $error("Chain did not switch active source");

   a_late_target: assert property (@(posedge clk) disable iff (rst)
      (late_ok && outranks) |=> act_idx == $past(best_idx) && vec_idx == $past(best_idx))
      else $error("Late arrival not made active");

   a_late_frame: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_STACK && outranks) |=> frame_len_q == $past(frame_len_q))
      else $error("Late arrival changed frame length");

   a_late_window: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_VECTOR && vec_done && first_exec && !outranks)
      |=> state_q == eerc_pkg::ST_HANDLER)
      else $error("Handler not entered after first execute");

   a_thread_take: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_THREAD && best_ok) |=> state_q == eerc_pkg::ST_STACK && take_ack)
      else $error("Eligible source not taken in thread mode");

   a_no_outrank: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_HANDLER && best_ok && !outranks && !handler_done)
      |=> state_q == eerc_pkg::ST_HANDLER && !take_ack)
      else $error("Source preempted without outranking");

   sequence s_unstack_step;
      state_q == eerc_pkg::ST_UNSTACK && stk_ready && word_q != frame_len_q - 5'h01;
   endsequence
   sequence s_unstack_last;
      state_q == eerc_pkg::ST_UNSTACK && stk_ready && word_q == frame_len_q - 5'h01;
   endsequence

   a_unstack_step: assert property (@(posedge clk) disable iff (rst)
      s_unstack_step |=> state_q == eerc_pkg::ST_UNSTACK && word_q == $past(word_q) + 5'h01)
      else $error("Unstacking disturbed");

   a_nest_pop: assert property (@(posedge clk) disable iff (rst)
      s_unstack_last |=> depth_q == $past(depth_q) - 4'h1 && restore_done)
      else $error("Nesting depth not lowered on return");

   a_nest_resume: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_UNSTACK && stk_ready && word_q == frame_len_q - 5'h01 && depth_q > 4'h1)
      |=> state_q == eerc_pkg::ST_HANDLER)
      else $error("Preempted handler not resumed");

   a_nest_full: assert property (@(posedge clk) disable iff (rst)
      (take_new && depth_q == 4'(DEPTH)) |=> !take_ack && depth_q == 4'(DEPTH))
      else $error("Entry taken with nesting full");

   a_idle_thread: assert property (@(posedge clk) disable iff (rst)
      (state_q == eerc_pkg::ST_THREAD && !best_ok) |=> state_q == eerc_pkg::ST_THREAD && !take_ack)
      else $error("Ineligible source taken");

   a_stack_push: assert property (@(posedge clk) disable iff (rst)
      state_q == eerc_pkg::ST_STACK |-> stk_req.valid && stk_req.push)
      else $error("Stacking not marked as push");

   a_fp_none: assert property (@(posedge clk) disable iff (rst)
      (take_new && fp_active && !fp_space && depth_q < 4'(DEPTH)) |=> frame_len_q == 5'h08)
      else $error("Frame without FP space not basic");

endmodule // eerc_core

// ### logic/eerc_map.svh
// Purpose: Constants for the exception entry and return sequencer
// Assumes: Included by bare name
// Notes:   Frame sizes are in 32-bit words
`ifndef EERC_MAP_SVH
`define EERC_MAP_SVH
`define EERC_BASIC_WORDS  8
`define EERC_FP_WORDS     18
`define EERC_PRIO_W       8
`define EERC_NUM_SRC      8
`define EERC_IDX_W        3
`define EERC_PRIO_NONE    8'hFF
`endif

// ### logic/eerc_pkg.sv
// Purpose: Types for the exception entry and return sequencer
// Assumes: Lower priority number means more urgent
// Notes:   None
package eerc_pkg;
   typedef enum logic [2:0] {
      ST_THREAD,
      ST_STACK,
      ST_VECTOR,
      ST_HANDLER,
      ST_UNSTACK
   } eerc_state_t;

   typedef struct packed {
      logic       valid;
      logic [4:0] word;
      logic       push;
   } eerc_stk_t;
endpackage
